// file: tmcg_mode_gate.sv
// Operating-mode supervisor and command gate with output path control.
`timescale 1ns/1ps
`default_nettype none
module tmcg_mode_gate
	import tmcg_pkg::*;
(
	input wire logic sys_clk, // 50 MHz clock
	input wire logic srst, // power-on reset, sync, active high
	input wire logic link_reset, // link reset pin, sync active high
	input wire logic presence_assert_pin, // physical presence level
	input wire logic fw_integ_fail, // boot firmware check failed, pulse
	input wire logic selftest_busy, // self-tests running, level
	input wire logic selftest_fail, // other self-test failed, pulse
	input wire logic cmd_valid, // parsed command header present, pulse
	input wire logic [31:0] cmd_code, // command code from parser
	input wire logic cmd_is_v20, // command belongs to 2.0 set
	input wire logic cmd_full_test, // self-test asks full test
	input wire logic fu_reload_prev, // upgrade start reloads old firmware
	input wire logic exec_done, // execution finished, pulse
	input wire logic exec_ok, // execution succeeded, with exec_done
	input wire logic upgrade_err, // upgrade command error detected, pulse
	input wire logic resp_has_data, // response carries data fields
	input wire logic key_busy, // key generation or zeroization active
	input wire logic resp_active, // response being shifted out
	input wire logic irq_event, // event to signal to host, pulse
	output logic dispatch, // command admitted, pulse
	output logic reject, // command refused, pulse
	output logic [31:0] reject_code, // error code with reject
	output logic data_path_en, // output data path connected
	output logic status_path_en, // output status path connected
	output logic hw_reset_loop, // shutdown reset loop request
	output logic host_interrupt_request, // interrupt to host
	output logic [2:0] mode_out // current mode
);
	// only link-facing ports exist; no maintenance access path.
	tmcg_mode_t mode_ff, nxt_mode;
	logic permit;
	logic [31:0] err_code;
	logic pend_ff; // a dispatched command awaits completion
	logic [31:0] pend_code_ff;
	logic pend_v20_ff, pend_full_ff, pend_reload_ff;
	logic has_data_ff;
	logic irq_ff;

	tmcg_cmd_filter u_filter (
		.mode(mode_ff),
		.cmd_code(cmd_code),
		.is_v20(cmd_is_v20),
		.permit(permit),
		.err_code(err_code)
	);

	// the parser delivers code and operands separately; we gate the code.
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			TMCG_LIMITED, TMCG_FULL: begin
				if (mode_ff == TMCG_LIMITED && pend_ff && exec_done && exec_ok &&
					pend_full_ff && (pend_v20_ff ? pend_code_ff == CC20_SELFTEST
					: pend_code_ff == CC12_SELFTEST))
					nxt_mode = TMCG_FULL;
				if (upgrade_err)
					nxt_mode = TMCG_REDUCED;
				if (selftest_fail)
					nxt_mode = TMCG_FAILURE;
			end
			TMCG_REDUCED: begin
				if (pend_ff && exec_done && exec_ok && pend_reload_ff &&
					(pend_code_ff == CC12_FUSTART || pend_code_ff == CC20_FUSTART))
					nxt_mode = TMCG_LIMITED;
				if (selftest_fail)
					nxt_mode = TMCG_FAILURE;
			end
			TMCG_FAILURE: nxt_mode = TMCG_FAILURE;
			TMCG_SHUTDOWN: nxt_mode = TMCG_SHUTDOWN;
			default: nxt_mode = TMCG_LIMITED;
		endcase
		if (fw_integ_fail)
			nxt_mode = TMCG_SHUTDOWN;
	end

	// Shutdown survives the link reset; only a power reset clears it.
	always_ff @(posedge sys_clk) begin
		if (srst)
			mode_ff <= TMCG_LIMITED;
		else if (link_reset && mode_ff != TMCG_SHUTDOWN)
			mode_ff <= TMCG_LIMITED;
		else
			mode_ff <= nxt_mode;
	end

	always_ff @(posedge sys_clk) begin
		if (srst || link_reset) begin
			dispatch <= 1'b0;
			reject <= 1'b0;
			reject_code <= RC_SUCCESS;
		end else begin
			dispatch <= cmd_valid && permit && !pend_ff;
			reject <= cmd_valid && !permit;
			reject_code <= (cmd_valid && !permit) ? err_code : RC_SUCCESS;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || link_reset) begin
			pend_ff <= 1'b0;
			pend_code_ff <= RC_SUCCESS;
			pend_v20_ff <= 1'b0;
			pend_full_ff <= 1'b0;
			pend_reload_ff <= 1'b0;
			has_data_ff <= 1'b0;
		end else if (cmd_valid && permit && !pend_ff) begin
			pend_ff <= 1'b1;
			pend_code_ff <= cmd_code;
			pend_v20_ff <= cmd_is_v20;
			pend_full_ff <= cmd_full_test;
			pend_reload_ff <= fu_reload_prev;
			has_data_ff <= 1'b0;
		end else if (exec_done) begin
			pend_ff <= 1'b0;
			has_data_ff <= exec_ok && resp_has_data;
		end else if (!resp_active && !pend_ff) begin
			has_data_ff <= 1'b0;
		end
	end

	// Blocking data is cheaper than proving each response clean in every error.
	always_ff @(posedge sys_clk) begin
		if (srst || link_reset) begin
			data_path_en <= 1'b0;
			status_path_en <= 1'b0;
		end else begin
			data_path_en <= resp_active && has_data_ff && !key_busy &&
				!selftest_busy && (mode_ff == TMCG_LIMITED ||
				mode_ff == TMCG_FULL);
			status_path_en <= resp_active && mode_ff != TMCG_SHUTDOWN;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst)
			hw_reset_loop <= 1'b0;
		else
			hw_reset_loop <= (mode_ff == TMCG_SHUTDOWN);
	end

	always_ff @(posedge sys_clk) begin
		if (srst || link_reset)
			irq_ff <= 1'b0;
		else if (irq_event || reject)
			irq_ff <= 1'b1;
		else if (resp_active)
			irq_ff <= 1'b0;
	end

	assign host_interrupt_request = irq_ff;
	assign mode_out = mode_ff;
	logic unused_pin;
	assign unused_pin = presence_assert_pin;
endmodule // tmcg_mode_gate
`default_nettype wire

// file: tmcg_pkg.sv
// Constants, command codes, error codes and mode types for the mode gate.
package tmcg_pkg;
	typedef enum logic [2:0] {
		TMCG_LIMITED = 3'h0,
		TMCG_FULL = 3'h1,
		TMCG_REDUCED = 3'h3,
		TMCG_FAILURE = 3'h2,
		TMCG_SHUTDOWN = 3'h6
	} tmcg_mode_t;
	localparam logic [31:0] CC12_STARTUP = 32'h00000099;
	localparam logic [31:0] CC12_GETCAP = 32'h00000065;
	localparam logic [31:0] CC12_TESTRES = 32'h00000054;
	localparam logic [31:0] CC12_CONTST = 32'h00000053;
	localparam logic [31:0] CC12_SELFTEST = 32'h00000050;
	localparam logic [31:0] CC12_FUSTART = 32'h000000aa;
	localparam logic [31:0] CC12_FUDATA = 32'h000000ab;
	localparam logic [31:0] CC20_GETCAP = 32'h0000017a;
	localparam logic [31:0] CC20_TESTRES = 32'h0000017c;
	localparam logic [31:0] CC20_SELFTEST = 32'h00000143;
	localparam logic [31:0] CC20_FUSTART = 32'h0000012f;
	localparam logic [31:0] CC20_FUDATA = 32'h00000141;
	localparam logic [31:0] ERR12_FAILED = 32'h0000001c;
	localparam logic [31:0] ERR20_FAILURE = 32'h00000101;
	localparam logic [31:0] ERR_CMD_CODE = 32'h00000143;
	localparam logic [31:0] RC_SUCCESS = 32'h00000000;
endpackage

// file: tmcg_cmd_filter.sv
// Per-mode command permission check and error code selection.
`timescale 1ns/1ps
`default_nettype none
module tmcg_cmd_filter
	import tmcg_pkg::*;
(
	input wire tmcg_mode_t mode, // current mode
	input wire logic [31:0] cmd_code, // command code
	input wire logic is_v20, // command uses the 2.0 set
	output logic permit, // command may execute
	output logic [31:0] err_code // mode error when refused
);
	always_comb begin
		permit = 1'b1;
		err_code = RC_SUCCESS;
		case (mode)
			TMCG_FAILURE: begin
				permit = is_v20 ? (cmd_code == CC20_GETCAP || cmd_code == CC20_TESTRES)
					: (cmd_code == CC12_STARTUP || cmd_code == CC12_GETCAP ||
					cmd_code == CC12_TESTRES);
				err_code = is_v20 ? ERR20_FAILURE : ERR12_FAILED;
			end
			TMCG_REDUCED: begin
				permit = is_v20 ? (cmd_code == CC20_FUSTART || cmd_code == CC20_FUDATA ||
					cmd_code == CC20_GETCAP || cmd_code == CC20_TESTRES ||
					cmd_code == CC20_SELFTEST)
					: (cmd_code == CC12_FUSTART || cmd_code == CC12_FUDATA ||
					cmd_code == CC12_GETCAP || cmd_code == CC12_TESTRES ||
					cmd_code == CC12_CONTST);
				err_code = ERR_CMD_CODE;
			end
			TMCG_SHUTDOWN: begin
				permit = 1'b0;
				err_code = is_v20 ? ERR20_FAILURE : ERR12_FAILED;
			end
			default: begin
				permit = 1'b1;
				err_code = RC_SUCCESS;
			end
		endcase
	end
endmodule // tmcg_cmd_filter
`default_nettype wire

// file: tmcg_mode_gate_assertions.sv
// Concurrent checks on the mode gate ports.
`timescale 1ns/1ps
`default_nettype none
module tmcg_mode_gate_checker
	import tmcg_pkg::*;
(
	input wire logic sys_clk, srst, link_reset, fw_integ_fail, selftest_fail,
	input wire logic selftest_busy, key_busy, resp_active, cmd_valid,
	input wire logic cmd_is_v20, cmd_full_test, exec_done, exec_ok, dispatch,
	input wire logic reject, data_path_en, status_path_en, hw_reset_loop,
	input wire logic [31:0] cmd_code, reject_code,
	input wire logic [2:0] mode_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst || link_reset);
	sequence s_full_taken;
		cmd_valid && cmd_full_test && !cmd_is_v20 && cmd_code == CC12_SELFTEST
			&& mode_out == 3'h0;
	endsequence
	sequence s_exec_ok;
		exec_done && exec_ok;
	endsequence
	AST_LIMIT_TO_FULL:
	assert property (s_full_taken ##1 dispatch ##[1:20] s_exec_ok
		|=> ##[0:1] mode_out == 3'h1) else $error("full mode not reached");
	AST_FAIL_CODE:
	assert property (reject && mode_out == 3'h2 |-> reject_code ==
		($past(cmd_is_v20) ? ERR20_FAILURE : ERR12_FAILED)) else $error("code");
	AST_RED_CODE:
	assert property (reject && mode_out == 3'h3 |-> reject_code == ERR_CMD_CODE)
		else $error("reduced code");
	AST_SHUT_ENTRY:
	assert property (fw_integ_fail |=> ##[0:1] mode_out == 3'h6 && hw_reset_loop)
		else $error("no shutdown");
	AST_SHUT_STAY:
	assert property (mode_out == 3'h6 |=> mode_out == 3'h6 && hw_reset_loop)
		else $error("left shutdown");
	AST_FAIL_ENTRY:
	assert property (selftest_fail && !fw_integ_fail && mode_out != 3'h6
		|=> ##[0:1] mode_out == 3'h2) else $error("no failure mode");
	AST_DATA_BLOCK:
	assert property (selftest_busy || key_busy || mode_out[1] |=> !data_path_en)
		else $error("data path open");
	AST_DATA_RESP:
	assert property (data_path_en |-> $past(resp_active)) else $error("no resp");
	AST_STATUS:
	assert property (resp_active && mode_out != 3'h6 |=> status_path_en)
		else $error("status path closed");
endmodule // tmcg_mode_gate_checker
bind tmcg_mode_gate tmcg_mode_gate_checker tmcg_mode_gate_checker_i (.*);
`default_nettype wire

// file: tmcg_host_model.sv
// Host-side command source standing in for the link controller.
`timescale 1ns/1ps
`default_nettype none
module tmcg_host_model (
	input wire logic sys_clk, // clock
	output logic cmd_valid, cmd_is_v20, cmd_full_test, fu_reload_prev, // command
	output logic presence_assert_pin, // presence level, held low
	output logic [31:0] cmd_code // command code
);
	initial begin
		{cmd_valid, cmd_is_v20, cmd_full_test, fu_reload_prev} = 4'h0;
		presence_assert_pin = 1'b0;
		cmd_code = 32'h0;
	end
	// Fields are inverted after the pulse so stale values are never trusted.
	task automatic send(input logic [31:0] c, input logic v, f, r);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		{cmd_is_v20, cmd_full_test, fu_reload_prev} <= {v, f, r};
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		cmd_code <= ~c;
		{cmd_is_v20, cmd_full_test, fu_reload_prev} <= ~{v, f, r};
	endtask
endmodule // tmcg_host_model
`default_nettype wire

// file: test_tmcg_mode_gate.sv
// Self-checking bench for the mode gate.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) comparisons++; \
	if ((a) !== (b)) begin \
		num_errors++; \
		$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
	end
module test_tmcg_mode_gate import tmcg_pkg::*;;
	logic sys_clk, srst, link_reset, fw_integ_fail, selftest_busy, selftest_fail;
	logic exec_done, exec_ok, upgrade_err, resp_has_data, key_busy, resp_active;
	logic irq_event, cmd_valid, cmd_is_v20, cmd_full_test, fu_reload_prev;
	logic presence_assert_pin, dispatch, reject, data_path_en, status_path_en;
	logic hw_reset_loop, host_interrupt_request;
	logic [31:0] cmd_code, reject_code;
	logic [2:0] mode_out;
	int num_errors = 0, comparisons = 0, cycles = 0;
	localparam logic [31:0] RED_OK [10] = '{CC12_FUSTART, CC12_FUDATA,
		CC12_GETCAP, CC12_TESTRES, CC12_CONTST, CC20_FUSTART, CC20_FUDATA,
		CC20_GETCAP, CC20_TESTRES, CC20_SELFTEST};
	localparam logic [31:0] FAIL_OK [5] = '{CC12_STARTUP, CC12_GETCAP,
		CC12_TESTRES, CC20_GETCAP, CC20_TESTRES};
	tmcg_mode_gate tmcg_mode_gate_i (.*);
	tmcg_host_model tmcg_host_model_i (.*);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			results();
		end
	end
	task automatic results();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic rst();
		srst <= 1'b1;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	// Pulses {firmware check, self-test, upgrade} failure lines together.
	task automatic ev(input logic [2:0] e);
		{fw_integ_fail, selftest_fail, upgrade_err} <= e;
		@(posedge sys_clk);
		{fw_integ_fail, selftest_fail, upgrade_err} <= 3'h0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic cmd(input logic [31:0] c, input logic v, f, r, ok,
		input logic [31:0] ec, input logic d, de);
		int n;
		n = 0;
		tmcg_host_model_i.send(c, v, f, r);
		#1;
		while (dispatch !== 1'b1 && reject !== 1'b1 && n < 4) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		`CHK(dispatch, ok)
		`CHK(reject_code, ec)
		if (ok) begin
			@(posedge sys_clk);
			{exec_done, exec_ok, resp_has_data} <= {2'h3, d};
			@(posedge sys_clk);
			exec_done <= 1'b0;
			resp_active <= 1'b1;
			repeat (2) @(posedge sys_clk);
			#1;
			`CHK(data_path_en, de)
			`CHK(status_path_en, 1'b1)
			@(posedge sys_clk);
			resp_active <= 1'b0;
		end
		#1;
	endtask
	initial begin
		{srst, link_reset, fw_integ_fail, selftest_busy, selftest_fail} = 5'h10;
		{exec_done, exec_ok, upgrade_err, resp_has_data, key_busy} = 5'h0;
		{resp_active, irq_event} = 2'h0;
		rst();
		`CHK(mode_out, 3'h0)
		cmd(CC12_TESTRES, 0, 0, 0, 1, RC_SUCCESS, 1, 1);
		selftest_busy <= 1'b1;
		cmd(CC12_GETCAP, 0, 0, 0, 1, RC_SUCCESS, 1, 0);
		selftest_busy <= 1'b0;
		cmd(CC12_SELFTEST, 0, 1, 0, 1, RC_SUCCESS, 0, 0);
		`CHK(mode_out, 3'h1)
		key_busy <= 1'b1;
		cmd(CC20_GETCAP, 1, 0, 0, 1, RC_SUCCESS, 1, 0);
		key_busy <= 1'b0;
		$display("limited and full test done");
		ev(3'h1);
		`CHK(mode_out, 3'h3)
		cmd(CC12_STARTUP, 0, 0, 0, 0, ERR_CMD_CODE, 0, 0);
		// The interrupt flag is set from the registered reject, one edge later.
		@(posedge sys_clk);
		#1;
		`CHK(host_interrupt_request, 1'b1)
		for (int i = 0; i < 10; i++)
			cmd(RED_OK[i], i > 4, 0, 0, 1, RC_SUCCESS, 1, 0);
		cmd(CC12_FUSTART, 0, 0, 1, 1, RC_SUCCESS, 0, 0);
		`CHK(mode_out, 3'h0)
		$display("reduced mode test done");
		rst();
		ev(3'h2);
		`CHK(mode_out, 3'h2)
		for (int i = 0; i < 5; i++)
			cmd(FAIL_OK[i], i > 2, 0, 0, 1, RC_SUCCESS, 1, 0);
		cmd(CC12_SELFTEST, 0, 1, 0, 0, ERR12_FAILED, 0, 0);
		cmd(CC20_SELFTEST, 1, 1, 0, 0, ERR20_FAILURE, 0, 0);
		$display("failure mode test done");
		rst();
		ev(3'h7);
		`CHK(mode_out, 3'h6)
		link_reset <= 1'b1;
		@(posedge sys_clk);
		link_reset <= 1'b0;
		ev(3'h0);
		`CHK(hw_reset_loop, 1'b1)
		cmd(CC12_GETCAP, 0, 0, 0, 0, ERR12_FAILED, 0, 0);
		$display("shutdown test done");
		results();
	end
endmodule // test_tmcg_mode_gate
`default_nettype wire
